//--- hw/ccc_pkg.sv
// constants and types shared by the coulomb counter core
// How it works
// - discharge pulse adds one discharge charge count
// - discharge time advances each tick while discharging
// - charge pulse adds one charge count
// - charge time advances each tick while charging
// - time counters are 16 bits and wrap
// - wrap sets slow flag, rate drops 256 fold
// - discharge time: 0.8789 s tick, slow 225 s
// - charge time: 0.8789 s tick, slow 225 s
// - self discharge counts hourly at 25 C
// - rate doubles per 10 C up to 60 C
// - rate halves per 10 C down to 0 C
// - chopped converter sign cancels offset over two ticks
// - sleep waits until activity below threshold
// - threshold code 0 none, 1..7 descending
// - sleeping core wakes briefly per update
// - serial pin edge ends sleep
// - normal all, sleep self discharge, hibernate none
// - hibernate holds state until supply returns
// - clear bit written one zeroes its counter
// - clear bit returns to zero when done
// - clearing time counter drops slow flag
`default_nettype none
package ccc_pkg;
  // timebase: one time tick is 0.8789 s
  localparam int unsigned CLK_KHZ = 25000;
  localparam longint unsigned TICK_NS = 64'd878900000;
  localparam int unsigned TICK_CYCLES = int'(TICK_NS * CLK_KHZ / 64'd1000000);
  localparam int unsigned TICK_W = 25;
  // slow rate: 256 ticks, about 225 s, per count
  localparam logic [7:0] SLOW_LAST = 8'hff;
  // self discharge period in ticks at the coldest bucket (4096 x 8)
  localparam logic [15:0] SD_BASE = 16'h8000;
  localparam logic [7:0] TEMP_MAX = 8'h3c;
  localparam logic [7:0] TEMP_RND = 8'h05;
  localparam logic [7:0] TEMP_STEP = 8'h0a;
  // quiet window ticks = code * 7 / 2
  localparam logic [5:0] WIN_MUL = 6'h07;
  // register map
  localparam logic [6:0] ADDR_FCMD = 7'h62;
  localparam logic [6:0] ADDR_CLR = 7'h63;
  localparam logic [6:0] ADDR_MODE = 7'h64;
  localparam logic [6:0] ADDR_CHG_TIME_LO = 7'h65;
  localparam logic [6:0] ADDR_CHG_TIME_HI = 7'h66;
  localparam logic [6:0] ADDR_DIS_TIME_LO = 7'h67;
  localparam logic [6:0] ADDR_DIS_TIME_HI = 7'h68;
  localparam logic [6:0] ADDR_SELF_LO = 7'h69;
  localparam logic [6:0] ADDR_SELF_HI = 7'h6a;
  localparam logic [6:0] ADDR_CHG_LO = 7'h6b;
  localparam logic [6:0] ADDR_CHG_HI = 7'h6c;
  localparam logic [6:0] ADDR_DIS_LO = 7'h6d;
  localparam logic [6:0] ADDR_DIS_HI = 7'h6e;
  // field positions
  localparam int unsigned MODE_CHG_SLOW = 5;
  localparam int unsigned MODE_DIS_SLOW = 4;
  localparam int unsigned MODE_WAKE_LSB = 1;
  localparam int unsigned CLR_CHG_TIME = 4;
  localparam int unsigned CLR_DIS_TIME = 3;
  localparam int unsigned CLR_SELF = 2;
  localparam int unsigned CLR_CHG = 1;
  localparam int unsigned CLR_DIS = 0;
  localparam int unsigned ST_SLEEP_BIT = 2;
  localparam int unsigned ST_WAKE_BIT = 3;
  // sleep command code on the command register
  localparam logic [7:0] SLEEP_CMD = 8'h01;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_SETTLE = 5'h02,
    ST_SLEEP = 5'h04,
    ST_WAKE = 5'h08,
    ST_HIBER = 5'h10
  } ccc_mode_t;

  typedef struct packed {
    logic [6:0] addr;
    logic wr;
    logic [7:0] wdata;
  } ccc_reg_req_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] sub;
    logic slow;
  } ccc_time_t;

  typedef struct packed {
    logic pulse;
    logic neg;
    logic pin;
    logic supply;
    logic [7:0] temp;
  } ccc_pins_t;

  typedef struct packed {
    ccc_mode_t mode;
    ccc_pins_t s1;
    ccc_pins_t s2;
    logic pulse3;
    logic pin3;
    logic [TICK_W-1:0] tick;
    logic chop;
    logic [1:0] chop_s; // phase delayed to match the input synchroniser
    logic [15:0] dis;
    logic [15:0] chg;
    logic [15:0] self_cnt;
    logic [15:0] self_div;
    ccc_time_t dis_t;
    ccc_time_t chg_t;
    logic dis_seen;
    logic chg_seen;
    logic [2:0] wake_threshold_select;
    logic [4:0] clr;
    logic [5:0] win;
    logic win_act;
    logic [7:0] rd;
  } ccc_state_t;

  // supply sync starts high so reset does not fake a hibernate
  localparam ccc_state_t STATE_RST = '{
    mode: ST_NORMAL,
    s1: '{supply: 1'b1, default: '0},
    s2: '{supply: 1'b1, default: '0},
    default: '0
  };
endpackage : ccc_pkg
`default_nettype wire

//--- hw/ccc_core.sv
// coulomb counter core: charge, time and self discharge counters
`default_nettype none
module ccc_core #(
  parameter int unsigned TICK_CYCLES = ccc_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic vfc_pulse,
  input wire logic vfc_negative,
  input wire logic serial_pin,
  input wire logic supply_above_por,
  input wire logic [7:0] die_temp_c,
  input wire ccc_pkg::ccc_reg_req_t reg_req,
  output logic [7:0] reg_rd_data,
  output logic clock_stop,
  output logic brief_wake,
  output logic chop_phase
);

  ccc_pkg::ccc_state_t q;
  ccc_pkg::ccc_state_t d;
  logic pulse;
  logic neg;
  logic tick;
  logic pin_edge;
  logic run;
  logic dis_ev;
  logic chg_ev;
  logic wr_clr;
  logic wr_mode;
  logic wr_cmd;
  logic [7:0] temp_c;
  logic [2:0] temp_idx;
  logic [15:0] sd_period;
  logic [5:0] win_len;
  logic wr_clr_d;

  // one time counter: fast tick, or one count per 256 once wrapped
  function automatic ccc_pkg::ccc_time_t time_step(
    input ccc_pkg::ccc_time_t t,
    input logic en,
    input logic clr
  );
    ccc_pkg::ccc_time_t n;
    n = t;
    if (clr)
    begin
      n = '0;
    end
    else if (en)
    begin
      if (t.slow)
      begin
        n.sub = t.sub + 8'h01;
      end
      if (!t.slow || t.sub == ccc_pkg::SLOW_LAST)
      begin
        n.cnt = t.cnt + 16'h0001;
        if (t.cnt == 16'hffff)
        begin
          n.slow = 1'b1;
        end
      end
    end
    return n;
  endfunction : time_step

  // edges are taken between second and third flop, never the first
  assign pulse = q.s2.pulse & ~q.pulse3;
  assign pin_edge = q.s2.pin ^ q.pin3;
  // converter input is swapped each tick, so its offset flips sign
  // against the signal and cancels over two ticks; the phase used here
  // is two flops old so it lines up with the synchronised sign
  assign neg = q.s2.neg ^ q.chop_s[1];
  assign tick = q.tick == ccc_pkg::TICK_W'(TICK_CYCLES - 1);
  // charge and time counting only while fully awake
  assign run = q.mode == ccc_pkg::ST_NORMAL || q.mode == ccc_pkg::ST_SETTLE;
  assign dis_ev = run & pulse & neg;
  assign chg_ev = run & pulse & ~neg;

  // register strobes
  assign wr_clr = reg_req.wr && reg_req.addr == ccc_pkg::ADDR_CLR;
  assign wr_mode = reg_req.wr && reg_req.addr == ccc_pkg::ADDR_MODE;
  assign wr_cmd = reg_req.wr && reg_req.addr == ccc_pkg::ADDR_FCMD;

  // temperature clamped to 0..60 C, bucketed by 10 C around 25 C
  assign temp_c = q.s2.temp[7] ? 8'h00 :
    (q.s2.temp > ccc_pkg::TEMP_MAX ? ccc_pkg::TEMP_MAX : q.s2.temp);
  assign temp_idx = 3'((temp_c + ccc_pkg::TEMP_RND) / ccc_pkg::TEMP_STEP);
  assign sd_period = ccc_pkg::SD_BASE >> temp_idx;

  // quiet window length matching the threshold voltage
  assign win_len = 6'(({3'b000, q.wake_threshold_select} * ccc_pkg::WIN_MUL) >> 1);

  // next state
  always_comb
  begin
    d = q;
    d.s1 = {vfc_pulse, vfc_negative, serial_pin, supply_above_por, die_temp_c};
    d.s2 = q.s1;
    d.pulse3 = q.s2.pulse;
    d.pin3 = q.s2.pin;
    d.chop_s = {q.chop_s[0], q.chop};
    d.tick = tick ? '0 : q.tick + 1'b1;
    if (tick)
    begin
      d.chop = ~q.chop;
    end

    // direction seen during a tick decides which time counter runs
    d.dis_seen = (q.dis_seen & ~tick) | dis_ev;
    d.chg_seen = (q.chg_seen & ~tick) | chg_ev;
    d.dis_t = time_step(q.dis_t, run & tick & q.dis_seen,
      q.clr[ccc_pkg::CLR_DIS_TIME]);
    d.chg_t = time_step(q.chg_t, run & tick & q.chg_seen,
      q.clr[ccc_pkg::CLR_CHG_TIME]);

    // charge counters; a pending clear wins over a pulse
    if (q.clr[ccc_pkg::CLR_DIS])
    begin
      d.dis = '0;
    end
    else if (dis_ev)
    begin
      d.dis = q.dis + 16'h0001;
    end
    if (q.clr[ccc_pkg::CLR_CHG])
    begin
      d.chg = '0;
    end
    else if (chg_ev)
    begin
      d.chg = q.chg + 16'h0001;
    end

    // self discharge runs in every state but hibernate
    if (q.clr[ccc_pkg::CLR_SELF])
    begin
      d.self_cnt = '0;
      d.self_div = '0;
    end
    else if (tick && q.mode != ccc_pkg::ST_HIBER)
    begin
      if (q.self_div >= sd_period - 16'h0001)
      begin
        d.self_div = '0;
        d.self_cnt = q.self_cnt + 16'h0001;
        if (q.mode == ccc_pkg::ST_SLEEP)
        begin
          d.mode = ccc_pkg::ST_WAKE;
        end
      end
      else
      begin
        d.self_div = q.self_div + 16'h0001;
      end
    end

    // every clear completes in one cycle, then its bit drops
    d.clr = '0;
    if (wr_clr)
    begin
      d.clr = reg_req.wdata[4:0];
    end
    if (wr_mode)
    begin
      d.wake_threshold_select = reg_req.wdata[ccc_pkg::MODE_WAKE_LSB +: 3];
    end

    // power state machine
    case (q.mode)
      ccc_pkg::ST_NORMAL:
      begin
        if (wr_cmd && reg_req.wdata == ccc_pkg::SLEEP_CMD)
        begin
          d.mode = ccc_pkg::ST_SETTLE;
          d.win = '0;
          d.win_act = 1'b0;
        end
      end
      ccc_pkg::ST_SETTLE:
      begin
        d.win_act = q.win_act | pulse;
        if (q.wake_threshold_select == 3'h0)
        begin
          d.mode = ccc_pkg::ST_SLEEP;
        end
        else if (tick)
        begin
          if (q.win >= win_len - 6'h01)
          begin
            d.win = '0;
            d.win_act = 1'b0;
            if (!(q.win_act | pulse))
            begin
              d.mode = ccc_pkg::ST_SLEEP;
            end
          end
          else
          begin
            d.win = q.win + 6'h01;
          end
        end
      end
      ccc_pkg::ST_SLEEP:
      begin
        if (pin_edge)
        begin
          d.mode = ccc_pkg::ST_NORMAL;
        end
      end
      ccc_pkg::ST_WAKE:
      begin
        // the brief wake lasts one cycle only
        d.mode = pin_edge ? ccc_pkg::ST_NORMAL : ccc_pkg::ST_SLEEP;
      end
      ccc_pkg::ST_HIBER:
      begin
        d.mode = ccc_pkg::ST_HIBER;
      end
      default:
      begin
        d.mode = ccc_pkg::ST_NORMAL;
      end
    endcase
    // supply loss overrides everything; counters keep their values
    if (!q.s2.supply)
    begin
      d.mode = ccc_pkg::ST_HIBER;
    end
    else if (q.mode == ccc_pkg::ST_HIBER)
    begin
      d.mode = ccc_pkg::ST_NORMAL;
    end

    // read path has no side effects, so polling is harmless
    d.rd = 8'h00;
    case (reg_req.addr)
      ccc_pkg::ADDR_DIS_LO: d.rd = q.dis[7:0];
      ccc_pkg::ADDR_DIS_HI: d.rd = q.dis[15:8];
      ccc_pkg::ADDR_CHG_LO: d.rd = q.chg[7:0];
      ccc_pkg::ADDR_CHG_HI: d.rd = q.chg[15:8];
      ccc_pkg::ADDR_SELF_LO: d.rd = q.self_cnt[7:0];
      ccc_pkg::ADDR_SELF_HI: d.rd = q.self_cnt[15:8];
      ccc_pkg::ADDR_DIS_TIME_LO: d.rd = q.dis_t.cnt[7:0];
      ccc_pkg::ADDR_DIS_TIME_HI: d.rd = q.dis_t.cnt[15:8];
      ccc_pkg::ADDR_CHG_TIME_LO: d.rd = q.chg_t.cnt[7:0];
      ccc_pkg::ADDR_CHG_TIME_HI: d.rd = q.chg_t.cnt[15:8];
      ccc_pkg::ADDR_CLR: d.rd = {3'b000, q.clr};
      ccc_pkg::ADDR_MODE:
      begin
        d.rd[ccc_pkg::MODE_CHG_SLOW] = q.chg_t.slow;
        d.rd[ccc_pkg::MODE_DIS_SLOW] = q.dis_t.slow;
        d.rd[ccc_pkg::MODE_WAKE_LSB +: 3] = q.wake_threshold_select;
      end
      default: d.rd = 8'h00;
    endcase
  end

  // the main state register; wr_clr_d below is the only other flop
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      q <= ccc_pkg::STATE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign reg_rd_data = q.rd;
  assign clock_stop = q.mode[ccc_pkg::ST_SLEEP_BIT];
  assign brief_wake = q.mode[ccc_pkg::ST_WAKE_BIT];
  assign chop_phase = q.chop;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence seq_asleep_edge;
    q.mode == ccc_pkg::ST_SLEEP && pin_edge && q.s2.supply;
  endsequence

  sequence seq_back_normal;
    q.mode == ccc_pkg::ST_NORMAL;
  endsequence

  chk_clr_selfclear: assert property (
    q.clr != '0 && !wr_clr |=> q.clr == '0)
    else $error("clear bit did not drop");

  chk_clr_zeroes: assert property (
    q.clr[ccc_pkg::CLR_DIS] |=> q.dis == '0 && q.clr[ccc_pkg::CLR_DIS] == wr_clr_d)
    else $error("discharge count not cleared");

  chk_dis_count: assert property (
    dis_ev && !q.clr[ccc_pkg::CLR_DIS] |=> q.dis == $past(q.dis) + 16'h0001)
    else $error("discharge pulse not counted");

  chk_chg_count: assert property (
    chg_ev && !q.clr[ccc_pkg::CLR_CHG] |=> q.chg == $past(q.chg) + 16'h0001)
    else $error("charge pulse not counted");

  chk_time_wrap: assert property (
    run && tick && q.dis_seen && q.dis_t.cnt == 16'hffff && !q.dis_t.slow
    && !q.clr[ccc_pkg::CLR_DIS_TIME] |=> q.dis_t.slow && q.dis_t.cnt == '0)
    else $error("wrap did not set slow rate");

  chk_slow_rate: assert property (
    q.dis_t.slow && q.dis_t.sub != ccc_pkg::SLOW_LAST
    && !q.clr[ccc_pkg::CLR_DIS_TIME] |=> $stable(q.dis_t.cnt))
    else $error("slow counter stepped early");

  chk_slow_drop: assert property (
    q.clr[ccc_pkg::CLR_CHG_TIME] |=> !q.chg_t.slow && q.chg_t.cnt == '0)
    else $error("time clear kept slow rate");

  chk_sleep_frozen: assert property (
    q.mode == ccc_pkg::ST_SLEEP && q.clr == '0 |=> $stable(q.dis) && $stable(q.chg)
    && $stable(q.dis_t) && $stable(q.chg_t))
    else $error("counting while asleep");

  chk_hiber_frozen: assert property (
    q.mode == ccc_pkg::ST_HIBER && q.clr == '0 |=> $stable(q.self_cnt) && $stable(q.dis))
    else $error("counting in hibernate");

  chk_pin_wake: assert property (
    seq_asleep_edge |=> seq_back_normal)
    else $error("pin edge did not wake");

  chk_wake_brief: assert property (
    q.mode == ccc_pkg::ST_WAKE |=> q.mode != ccc_pkg::ST_WAKE)
    else $error("brief wake too long");

  // helper: clear write with the discharge count bit set, seen one cycle earlier
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_clr_d <= 1'b0;
    end
    else
    begin
      wr_clr_d <= wr_clr && reg_req.wdata[ccc_pkg::CLR_DIS];
    end
  end

endmodule : ccc_core
`default_nettype wire

//--- testbench/ccc_vfc_model.sv
// converter model: chopped pulse stream toward the counter core
`default_nettype none
module ccc_vfc_model #(
  parameter int unsigned PERIOD = 16
) (
  input wire logic clock,
  input wire logic enable,
  input wire logic discharge,
  input wire logic chop_phase,
  output logic vfc_pulse,
  output logic vfc_negative
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  initial
  begin
    cnt = 0;
    vfc_pulse = 1'b0;
    vfc_negative = 1'b0;
  end
  // sign follows the chop phase every cycle; the core lines its own
  // delayed copy of the phase up with the synchronised sign
  always @(negedge clock)
  begin
    vfc_negative = discharge ^ chop_phase; // input swapped in phase 1
    if (cnt != 0 || enable)
    begin
      cnt = (cnt + 1) % PERIOD;
      if (cnt == 2)
        vfc_pulse = 1'b1;
      if (cnt == PERIOD / 2 + 2)
        vfc_pulse = 1'b0;
    end
  end
endmodule : ccc_vfc_model
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the coulomb counter core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICKS = 20;
  // copy-to-flash command code; value arbitrary, the core ignores it
  localparam logic [7:0] SAVE_CMD = 8'h02;
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } ccc_row_t;
  // register rows: reset values, read-only counters, masked mode field
  localparam ccc_row_t ROWS [11] = '{
    '{1'b0, 7'h64, 8'h00, 8'h00}, '{1'b0, 7'h63, 8'h00, 8'h00}, '{1'b0, 7'h70, 8'h00, 8'h00},
    '{1'b1, 7'h64, 8'hff, 8'h00}, '{1'b0, 7'h64, 8'h00, 8'h0e}, '{1'b1, 7'h6d, 8'h55, 8'h00},
    '{1'b0, 7'h6d, 8'h00, 8'h00}, '{1'b1, 7'h63, 8'h00, 8'h00}, '{1'b0, 7'h63, 8'h00, 8'h00},
    '{1'b1, 7'h64, 8'h00, 8'h00}, '{1'b0, 7'h64, 8'h00, 8'h00}};
  logic clock;
  logic reset;
  logic vfc_pulse;
  logic vfc_negative;
  logic serial_pin;
  logic supply_above_por;
  logic [7:0] die_temp_c;
  logic [7:0] reg_rd_data;
  logic [7:0] b;
  logic [15:0] v;
  ccc_pkg::ccc_reg_req_t reg_req;
  logic clock_stop;
  logic brief_wake;
  logic chop_phase;
  logic vfc_en;
  logic vfc_dis;
  int fail_count;
  int n_checks;
  int n_dis;
  int n_chg;

  ccc_core #(.TICK_CYCLES(TICKS)) dut (.clock(clock), .reset(reset), .vfc_pulse(vfc_pulse),
    .vfc_negative(vfc_negative), .serial_pin(serial_pin), .supply_above_por(supply_above_por),
    .die_temp_c(die_temp_c), .reg_req(reg_req), .reg_rd_data(reg_rd_data), .clock_stop(clock_stop),
    .brief_wake(brief_wake), .chop_phase(chop_phase));
  ccc_vfc_model #(.PERIOD(16)) vfc (.clock(clock), .enable(vfc_en), .discharge(vfc_dis),
    .chop_phase(chop_phase), .vfc_pulse(vfc_pulse), .vfc_negative(vfc_negative));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // expected charge counts follow the pulses the model really sent
  always @(posedge vfc_pulse)
  begin
    if (vfc_dis)
      n_dis++;
    else
      n_chg++;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req = '{addr: a, wr: 1'b1, wdata: d};
    @(negedge clock);
    reg_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_req = '{addr: a, wr: 1'b0, wdata: 8'h00};
    @(negedge clock);
    d = reg_rd_data;
  endtask : rd
  task automatic rd16(input logic [6:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 7'h01, d[15:8]);
  endtask : rd16
  // bounded wait on clock_stop (0) or brief_wake (1)
  task automatic wait_for(input string name, input int which, input logic lvl, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clock);
      if ((which ? brief_wake : clock_stop) === lvl)
        break;
    end
    check(name, which ? brief_wake : clock_stop, lvl);
  endtask : wait_for
  task automatic pulses(input logic dis, input int cycles);
    @(negedge clock);
    vfc_dis = dis;
    vfc_en = 1'b1;
    repeat (cycles) @(negedge clock);
    vfc_en = 1'b0;
    repeat (30) @(negedge clock);
  endtask : pulses
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  initial
  begin
    // the longest wait is one self discharge period, about 10k cycles
    repeat (40000) @(posedge clock);
    fail_count++;
    results();
  end

  initial
  begin
    fail_count = 0;
    n_checks = 0;
    reset = 1'b1;
    reg_req = '0;
    serial_pin = 1'b0;
    supply_above_por = 1'b1;
    die_temp_c = 8'h3c;
    vfc_en = 1'b0;
    vfc_dis = 1'b1;
    repeat (2) @(negedge clock);
    check("rd_in_reset", {5'h00, clock_stop, brief_wake, chop_phase, reg_rd_data}, 16'h0000);
    reset = 1'b0;
    // the phase flips on the first tick, TICKS edges after release
    repeat (TICKS) @(negedge clock);
    check("chop_phase", chop_phase, 16'h0001);
    for (int a = 'h65; a <= 'h6d; a += 2)
    begin
      rd16(7'(a), v);
      check("counter_reset", v, 16'h0000);
    end
    $display("test reset done");
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        wr(ROWS[i].addr, ROWS[i].wdata);
      else
      begin
        rd(ROWS[i].addr, b);
        check("reg_row", b, ROWS[i].exp);
      end
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(7'h64, 8'(c << 1));
      rd(7'h64, b);
      check("wake_code", b, 16'(c << 1));
    end
    wr(7'h64, 8'h00);
    $display("test registers done");
    n_dis = 0;
    n_chg = 0;
    pulses(1'b1, TICKS * 6);
    rd16(7'h6d, v);
    check("dis_count", v, 16'(n_dis));
    rd16(7'h6b, v);
    check("chg_idle", v, 16'h0000);
    rd16(7'h67, v);
    // eight pulses 16 cycles apart fall into six or seven ticks
    check("dis_time", 16'(v >= 6 && v <= 7), 16'h0001);
    rd16(7'h65, v);
    check("chg_time_idle", v, 16'h0000);
    pulses(1'b0, TICKS * 6);
    rd16(7'h6b, v);
    check("chg_count", v, 16'(n_chg));
    rd16(7'h6d, v);
    check("dis_kept", v, 16'(n_dis));
    rd16(7'h65, v);
    check("chg_time", 16'(v >= 6 && v <= 7), 16'h0001);
    $display("test counting done");
    wr(7'h63, 8'h1f);
    // clear bits stand one cycle only; the write already put the address out
    @(negedge clock);
    b = reg_rd_data;
    check("clr_set", b, 16'h001f);
    rd(7'h63, b);
    check("clr_done", b, 16'h0000);
    for (int a = 'h65; a <= 'h6d; a += 2)
    begin
      rd16(7'(a), v);
      check("counter_clr", v, 16'h0000);
    end
    rd(7'h64, b);
    check("slow_flags_clr", b, 16'h0000);
    $display("test clear done");
    wr(7'h64, 8'h02);
    vfc_dis = 1'b0;
    vfc_en = 1'b1;
    wr(7'h62, SAVE_CMD);
    wr(7'h62, 8'h01);
    repeat (200) @(negedge clock);
    check("busy_no_sleep", clock_stop, 16'h0000);
    vfc_en = 1'b0;
    wait_for("sleep_quiet", 0, 1'b1, 200);
    pulses(1'b1, 100);
    serial_pin = 1'b1;
    wait_for("wake_rise", 0, 1'b0, 10);
    rd16(7'h6d, v);
    check("dis_asleep", v, 16'h0000);
    $display("test sleep done");
    wr(7'h63, 8'h04);
    wr(7'h64, 8'h00);
    wr(7'h62, SAVE_CMD);
    wr(7'h62, 8'h01);
    wait_for("sleep_now", 0, 1'b1, 20);
    wait_for("brief_wake", 1, 1'b1, 12000);
    serial_pin = 1'b0;
    wait_for("wake_fall", 0, 1'b0, 10);
    rd16(7'h69, v);
    check("self_count", v, 16'h0001);
    $display("test self discharge done");
    @(negedge clock);
    supply_above_por = 1'b0;
    repeat (10) @(negedge clock);
    pulses(1'b1, 100);
    supply_above_por = 1'b1;
    repeat (10) @(negedge clock);
    rd16(7'h6d, v);
    check("dis_hibernate", v, 16'h0000);
    rd16(7'h69, v);
    check("self_hibernate", v, 16'h0001);
    $display("test hibernate done");
    results();
  end
endmodule : testbench
`default_nettype wire
